/* File: tb/sar_adc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.vh"
// **********************
// port checker
// **********************
module sar_adc_checker (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       ADC_IRQ_EN,
  input wire logic       ADC_POWER_ON,
  input wire logic       DIFF_MODE,
  input wire logic [7:0] PIN_SEL_POS,
  input wire logic [7:0] PIN_SEL_NEG,
  input wire logic       SAR_SAMPLE,
  input wire logic       SAR_CLK_TICK,
  input wire logic       ADC_IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [2:0] sel;
  logic [5:0] nt;
  logic [7:0] gap;
  logic       seen;
  // shadow clock select, ticks per conversion, spacing of ticks
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sel <= 3'h0;
      nt <= 6'h00;
      gap <= 8'h00;
      seen <= 1'b0;
    end else begin
      if (SFR_WR && SFR_ADDR == `ADDR_CONFIG)
        sel <= SFR_WDATA[7:5];
      nt <= $rose(SAR_SAMPLE) ? 6'h00 : nt + {5'h00, SAR_CLK_TICK};
      gap <= SAR_CLK_TICK ? 8'h01 : gap + 8'h01;
      seen <= SAR_SAMPLE ? 1'b0 : (seen | SAR_CLK_TICK);
    end
  end
  chk_power_gate: assert property (SAR_SAMPLE |-> ADC_POWER_ON) else $error("sample while off");
  chk_pins_off: assert property (!ADC_POWER_ON |-> (PIN_SEL_POS | PIN_SEL_NEG) == 8'h00)
    else $error("pin routed while off");
  chk_single_pin: assert property (ADC_POWER_ON && !DIFF_MODE |-> $onehot(PIN_SEL_POS) && PIN_SEL_NEG == 8'h00)
    else $error("bad single-ended routing");
  chk_diff_pair: assert property (ADC_POWER_ON && DIFF_MODE |-> PIN_SEL_NEG == (PIN_SEL_POS << 1)
    && (PIN_SEL_POS & 8'hAA) == 8'h00 && $onehot(PIN_SEL_POS)) else $error("bad differential pair");
  chk_flag_sticky: assert property (ADC_IRQ && !(SFR_WR && SFR_ADDR == `ADDR_CONTROL) |=> ADC_IRQ || !ADC_IRQ_EN)
    else $error("done flag dropped by itself");
  // no start on a set flag
  chk_no_restart: assert property ($rose(SAR_SAMPLE) |-> !$past(ADC_IRQ)) else $error("start with flag set");
  chk_tick_count: assert property ($rose(ADC_IRQ) && $past(ADC_IRQ_EN) |-> (nt + {5'h00, SAR_CLK_TICK}) == 6'd24)
    else $error("conversion not 24 ticks");
  chk_tick_gap: assert property (SAR_CLK_TICK && seen && sel < 3'h6 |-> gap == (8'h02 << sel))
    else $error("wrong conversion clock spacing");
  cov_start: cover property ($rose(SAR_SAMPLE));
  cov_done: cover property ($rose(ADC_IRQ));
  cov_diff: cover property (SAR_SAMPLE && DIFF_MODE);
endmodule // sar_adc_checker
bind sar_adc_sequencer sar_adc_checker chk_u (.MCLK(MCLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
  .SFR_WDATA(SFR_WDATA), .ADC_IRQ_EN(ADC_IRQ_EN), .ADC_POWER_ON(ADC_POWER_ON), .DIFF_MODE(DIFF_MODE),
  .PIN_SEL_POS(PIN_SEL_POS), .PIN_SEL_NEG(PIN_SEL_NEG), .SAR_SAMPLE(SAR_SAMPLE), .SAR_CLK_TICK(SAR_CLK_TICK),
  .ADC_IRQ(ADC_IRQ));
`default_nettype wire

/* File: tb/sar_comp_model.sv */
`timescale 1ns/1ns
`default_nettype none
// **********************
// comparator far side
// **********************
module sar_comp_model #(
  parameter logic [7:0] LEVELS = 8'h55
) (
  input  wire logic       clk,
  input  wire logic [7:0] pos,
  input  wire logic       sample,
  input  wire logic       tick,
  output var  logic       comp
);
  initial comp = 1'b0;
  // steady decision per routed pin; settles well before the first bit is taken
  always @(posedge clk) begin
    comp <= |(pos & LEVELS);
  end
endmodule // sar_comp_model
`default_nettype wire

/* File: tb/test_sar_adc_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.vh"
// **********************
// bench top
// **********************
module test_sar_adc_sequencer;
  localparam logic [7:0] CF = `ADDR_CONFIG;
  localparam logic [7:0] CT = `ADDR_CONTROL;
  logic       MCLK = 1'b0;
  logic       RST = 1'b1;
  logic [7:0] SFR_ADDR = 8'h00;
  logic       SFR_WR = 1'b0;
  logic [7:0] SFR_WDATA = 8'h00;
  logic       ADC_IRQ_EN = 1'b1;
  logic       SPLIT = 1'b0;
  logic       t0 = 1'b0, t3 = 1'b0, t3l = 1'b0, u1 = 1'b0;
  wire logic  [7:0] SFR_RDATA, PIN_SEL_POS, PIN_SEL_NEG;
  wire logic  ADC_POWER_ON, DIFF_MODE, AUTOZERO_ON, SAR_SAMPLE, SAR_CLK_TICK, COMP_OUT, ADC_IRQ;
  int         mismatches = 0, n_tests = 0, cyc = 0, t_start, i;
  logic [7:0] d;
  sar_adc_sequencer dut_u (.MCLK(MCLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA), .ADC_IRQ_EN(ADC_IRQ_EN), .TIMER0_OVERFLOW_TICK(t0), .TIMER3_OVERFLOW_TICK(t3),
    .TIMER3_LOW_OVERFLOW_TICK(t3l), .TIMER3_SPLIT(SPLIT), .UART1_RATE_OVERFLOW_TICK(u1),
    .ADC_POWER_ON(ADC_POWER_ON), .DIFF_MODE(DIFF_MODE), .AUTOZERO_ON(AUTOZERO_ON), .PIN_SEL_POS(PIN_SEL_POS),
    .PIN_SEL_NEG(PIN_SEL_NEG), .SAR_SAMPLE(SAR_SAMPLE), .SAR_CLK_TICK(SAR_CLK_TICK), .COMP_OUT(COMP_OUT),
    .ADC_IRQ(ADC_IRQ));
  sar_comp_model cmp_u (.clk(MCLK), .pos(PIN_SEL_POS), .sample(SAR_SAMPLE), .tick(SAR_CLK_TICK), .comp(COMP_OUT));
  always #50 MCLK = ~MCLK;
  // overflow ticks at unrelated periods
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    t0 <= (cyc % 7) == 0;
    t3 <= (cyc % 3) == 0;
    t3l <= (cyc % 5) == 0;
    u1 <= (cyc % 4) == 0;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge MCLK);
    SFR_ADDR <= a;
    SFR_WDATA <= v;
    SFR_WR <= 1'b1;
    @(posedge MCLK);
    SFR_WR <= 1'b0;
  endtask
  // address one edge, registered data the next
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    SFR_ADDR <= a;
    @(posedge MCLK);
    @(negedge MCLK);
    d = SFR_RDATA;
    chk(d, exp);
  endtask
  // poll the done flag under a bound
  task automatic wait_done;
    d = 8'h00;
    for (int k = 0; k < 1200 && d[4] !== 1'b1; k++) begin
      @(posedge MCLK);
      SFR_ADDR <= CT;
      @(posedge MCLK);
      @(negedge MCLK);
      d = SFR_RDATA;
    end
    if (d[4] !== 1'b1) begin
      mismatches++;
      wrap_up;
    end
  endtask
  task automatic conv(input logic [7:0] cfg, input logic [7:0] ctl, input logic [7:0] hi, input logic [7:0] lo,
                      input int p);
    wr(CF, cfg);
    wr(CT, ctl & 8'hF7);
    repeat (8) @(posedge MCLK);
    t_start = cyc;
    wr(CT, ctl);
    wait_done;
    chk({7'h00, (cyc - t_start) >= 23 * p && (cyc - t_start) <= 25 * p + 8}, 8'h01);
    rchk(`ADDR_RESULT_HIGH, hi);
    rchk(`ADDR_RESULT_LOW, lo);
    rchk(CT, ctl ^ 8'h18);
    wr(CT, ctl & 8'hE7);
  endtask
  initial begin
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    rchk(CF, `CFG_RESET);
    rchk(CT, `CTL_RESET);
    rchk(8'hC7, 8'h00);
    chk(PIN_SEL_POS, 8'h00);
    // single-ended routing then differential pairs with auto-zero
    for (i = 0; i < 12; i++) begin
      wr(CT, i < 8 ? 8'h80 | i[7:0] : 8'hE0 | ((i[7:0] - 8'h08) << 1));
      @(negedge MCLK);
      chk(PIN_SEL_POS, i < 8 ? 8'h01 << i : 8'h01 << (2 * (i - 8)));
      chk(PIN_SEL_NEG, i < 8 ? 8'h00 : 8'h02 << (2 * (i - 8)));
      chk({6'h00, DIFF_MODE, AUTOZERO_ON}, i < 8 ? 8'h00 : 8'h03);
    end
    wr(CT, 8'h80);
    repeat (50) @(posedge MCLK);
    // every clock source at a legal rate, split timer last
    for (i = 0; i < 9; i++) begin
      SPLIT <= (i == 8);
      conv({i < 8 ? i[2:0] : 3'h7, 5'h00}, 8'h88, 8'hFF, 8'hF0,
           i < 6 ? 2 << i : (i == 6 ? 8 : (i == 7 ? 6 : 10)));
    end
    conv(8'h10, 8'h88, 8'h0F, 8'hFF, 2);
    conv(8'h10, 8'h89, 8'h00, 8'h00, 2);
    wr(CT, 8'h90);
    rchk(CT, 8'h80);
    rchk(`ADDR_RESULT_LOW, 8'h00);
    // a zero written to go does not stop the running conversion
    wr(CT, 8'h88);
    wr(CT, 8'h80);
    wait_done;
    rchk(CT, 8'h90);
    rchk(`ADDR_RESULT_HIGH, 8'h0F);
    @(posedge MCLK);
    ADC_IRQ_EN <= 1'b0;
    @(negedge MCLK);
    chk({7'h00, ADC_IRQ}, 8'h00);
    @(posedge MCLK);
    ADC_IRQ_EN <= 1'b1;
    @(negedge MCLK);
    chk({7'h00, ADC_IRQ}, 8'h01);
    wr(CT, 8'h80);
    rchk(CT, 8'h80);
    // hardware triggers repeat until power is removed
    for (i = 1; i < 4; i++) begin
      wr(CF, i[7:0]);
      wr(CT, 8'h80);
      repeat (50) @(posedge MCLK);
      wr(CT, 8'h88);
      wait_done;
      rchk(CT, 8'h98);
      wr(CT, 8'h80);
      wait_done;
      wr(CT, 8'h00);
      rchk(CT, 8'h00);
    end
    // reserved config bits, then a reset with the converter powered off
    wr(CF, 8'hFF);
    rchk(CF, `CFG_WMASK);
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    rchk(CF, `CFG_RESET);
    wrap_up;
  end
endmodule // test_sar_adc_sequencer
`default_nettype wire

/* File: verilog/adc_clk_gen.v */
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.vh"

// ******************************************************
// conversion clock tick generator
// ******************************************************
module adc_clk_gen (
  input  wire       clk,
  input  wire       rst,
  input  wire       enable,
  input  wire [2:0] sel,
  input  wire       uart1_tick,
  input  wire       timer3_tick,
  output reg        tick
);

  reg  [6:0] sys_count;
  reg        half;
  wire [6:0] next_sys_count;
  wire       src_tick;
  wire       sys_wrap;

  // sys divider wraps at 2^(sel+1)-1
  assign next_sys_count = sys_count + 7'h01;
  assign sys_wrap       = (sys_count == ((7'h02 << sel) - 7'h01));

  // source tick: direct sys division, or half rate of an overflow
  assign src_tick = (sel == `CLKSEL_UART1)  ? uart1_tick :
                    (sel == `CLKSEL_TIMER3) ? timer3_tick : 1'b0;

  // divide and emit one-cycle tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_count <= 7'h00;
      half      <= 1'b0;
      tick      <= 1'b0;
    end else if (!enable) begin
      sys_count <= 7'h00;
      half      <= 1'b0;
      tick      <= 1'b0;
    end else if (sel >= `CLKSEL_UART1) begin
      sys_count <= 7'h00;
      if (src_tick) begin
        half <= ~half;
      end
      tick <= src_tick & half;
    end else begin
      sys_count <= sys_wrap ? 7'h00 : next_sys_count;
      tick      <= sys_wrap;
    end
  end

endmodule // adc_clk_gen
`default_nettype wire

/* File: verilog/adc_result_pack.v */
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.vh"

// ******************************************************
// justifies a 12-bit result into two bytes
// ******************************************************
module adc_result_pack (
  input  wire        right_justify,
  input  wire [11:0] value,
  output wire [7:0]  high_byte,
  output wire [7:0]  low_byte
);

  // unused positions read zero
  assign high_byte = right_justify ? {4'h0, value[11:8]} : value[11:4];
  assign low_byte  = right_justify ? value[7:0] : {value[3:0], 4'h0};

endmodule // adc_result_pack
`default_nettype wire

/* File: verilog/adc_seq_defs.vh */
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// ******************************************************
// register addresses
// ******************************************************
`define ADDR_CONFIG       8'hC3
`define ADDR_CONTROL      8'hC4
`define ADDR_RESULT_LOW   8'hC5
`define ADDR_RESULT_HIGH  8'hC6

// ******************************************************
// control register fields
// ******************************************************
`define CTL_POWER_ON      7
`define CTL_DIFF_MODE     6
`define CTL_AUTOZERO      5
`define CTL_DONE          4
`define CTL_GO            3
`define CTL_CHAN_HI       2
`define CTL_CHAN_LO       0
`define CTL_RESET         8'h00

// ******************************************************
// config register fields
// ******************************************************
`define CFG_CLK_HI        7
`define CFG_CLK_LO        5
`define CFG_RJUST         4
`define CFG_TRIG_HI       1
`define CFG_TRIG_LO       0
`define CFG_RESET         8'h00
`define CFG_WMASK         8'hF3

// ******************************************************
// clock select and trigger codes
// ******************************************************
`define CLKSEL_UART1      3'h6
`define CLKSEL_TIMER3     3'h7
`define TRIG_SOFT         2'h0
`define TRIG_TIMER0       2'h1
`define TRIG_FREE         2'h2
`define TRIG_TIMER3       2'h3

// ******************************************************
// timing
// ******************************************************
`define CONV_CYCLES       5'd24
`define CONV_LAST         5'd23
`define RESULT_ZERO       12'h000
`define SAR_BITS          5'd12
`define SAR_MSB           4'd11
`define COUNT_ZERO        5'd0
`define COUNT_STEP        5'd1

`endif

/* File: verilog/sar_adc_sequencer.v */
// Contract
// - power bit off keeps converter shut down
// - clock select picks divider or overflow
// - conversion lasts 24 conversion clocks
// - completion clears go (soft trigger only), sets flag, loads
// - no start while busy or flag high
// - write one starts, write zero ignored
// - flag sticky until written zero; interrupt
// - timer or free triggers keep converting
// - single-ended routes pin of chan_sel
// - differential uses pin pairs, signed result; the result loads the same SAR value as single-ended
// - bit six selects differential mode
// - bit five enables auto-zero
// - left justify: 8 high, 4 low top
// - right justify: 4 high low, 8 low
// - split timer3 uses low-byte overflow
// - conversion in idle completes and wakes
// - trigger select chooses start source
// - unused result bits read zero
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.vh"

module sar_adc_sequencer (
  input  wire        MCLK,
  input  wire        RST,
  input  wire [7:0]  SFR_ADDR,
  input  wire        SFR_WR,
  input  wire [7:0]  SFR_WDATA,
  output reg  [7:0]  SFR_RDATA,
  input  wire        ADC_IRQ_EN,
  input  wire        TIMER0_OVERFLOW_TICK,
  input  wire        TIMER3_OVERFLOW_TICK,
  input  wire        TIMER3_LOW_OVERFLOW_TICK,
  input  wire        TIMER3_SPLIT,
  input  wire        UART1_RATE_OVERFLOW_TICK,
  output wire        ADC_POWER_ON,
  output wire        DIFF_MODE,
  output wire        AUTOZERO_ON,
  output wire [7:0]  PIN_SEL_POS,
  output wire [7:0]  PIN_SEL_NEG,
  output reg         SAR_SAMPLE,
  output reg         SAR_CLK_TICK,
  input  wire        COMP_OUT,
  output wire        ADC_IRQ
);

  // ******************************************************
  // registers and internal signals
  // ******************************************************
  reg  [7:0]  adc_control;
  reg  [7:0]  adc_config;
  reg  [11:0] result;
  reg  [11:0] sar;
  reg  [4:0]  count;
  reg         busy;
  reg  [1:0]  comp_sync;
  wire        conv_tick;
  wire        timer3_sel_tick;
  wire        power_on;
  wire        conv_go;
  wire        conv_done_flag;
  wire [2:0]  chan_sel;
  wire [1:0]  trigger_sel;
  wire        hw_trigger;
  wire        start;
  wire        finish;
  wire        wr_control;
  wire        wr_config;
  wire [7:0]  result_high;
  wire [7:0]  result_low;
  wire [11:0] next_sar;
  wire [3:0]  bit_index;

  assign power_on       = adc_control[`CTL_POWER_ON];
  assign conv_go        = adc_control[`CTL_GO];
  assign conv_done_flag = adc_control[`CTL_DONE];
  assign chan_sel       = adc_control[`CTL_CHAN_HI:`CTL_CHAN_LO];
  assign trigger_sel    = adc_config[`CFG_TRIG_HI:`CFG_TRIG_LO];
  assign wr_control     = SFR_WR && (SFR_ADDR == `ADDR_CONTROL);
  assign wr_config      = SFR_WR && (SFR_ADDR == `ADDR_CONFIG);

  // ******************************************************
  // comparator synchroniser
  // ******************************************************
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      comp_sync <= 2'b00;
    end else begin
      comp_sync <= {comp_sync[0], COMP_OUT};
    end
  end

  // ******************************************************
  // conversion clock
  // ******************************************************
  // split low-byte overflow
  assign timer3_sel_tick = TIMER3_SPLIT ? TIMER3_LOW_OVERFLOW_TICK : TIMER3_OVERFLOW_TICK;

  adc_clk_gen u_clk_gen (
    .clk         (MCLK),
    .rst         (RST),
    .enable      (power_on),
    .sel         (adc_config[`CFG_CLK_HI:`CFG_CLK_LO]),
    .uart1_tick  (UART1_RATE_OVERFLOW_TICK),
    .timer3_tick (timer3_sel_tick),
    .tick        (conv_tick)
  );

  // ******************************************************
  // start and finish conditions
  // ******************************************************
  // start source select
  assign hw_trigger = (trigger_sel == `TRIG_FREE) ||
                      ((trigger_sel == `TRIG_TIMER0) && TIMER0_OVERFLOW_TICK) ||
                      ((trigger_sel == `TRIG_TIMER3) && timer3_sel_tick);

  // block while flag high; repeat on triggers
  assign start = power_on && conv_go && !busy && !conv_done_flag &&
                 ((trigger_sel == `TRIG_SOFT) || hw_trigger);

  assign finish = busy && conv_tick && (count == `CONV_LAST);

  // successive approximation step: current bit kept per comparator
  assign bit_index = `SAR_MSB - count[3:0];
  assign next_sar  = sar | (comp_sync[1] ? (12'h001 << bit_index) : `RESULT_ZERO);

  // ******************************************************
  // conversion sequencer
  // ******************************************************
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      busy         <= 1'b0;
      count        <= `COUNT_ZERO;
      sar          <= `RESULT_ZERO;
      SAR_SAMPLE   <= 1'b0;
      SAR_CLK_TICK <= 1'b0;
    end else begin
      SAR_CLK_TICK <= busy && conv_tick;
      if (!power_on) begin
        busy       <= 1'b0;
        count      <= `COUNT_ZERO;
        SAR_SAMPLE <= 1'b0;
      end else if (start) begin
        busy       <= 1'b1;
        count      <= `COUNT_ZERO;
        sar        <= `RESULT_ZERO;
        SAR_SAMPLE <= 1'b1;
      end else if (busy && conv_tick) begin
        SAR_SAMPLE <= 1'b0;
        if (count < `SAR_BITS) begin
          sar <= next_sar;
        end
        if (count == `CONV_LAST) begin
          busy  <= 1'b0;
          count <= `COUNT_ZERO;
        end else begin
          count <= count + `COUNT_STEP;
        end
      end
    end
  end

  // ******************************************************
  // result holding register
  // ******************************************************
  // hold until next completion
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      result <= `RESULT_ZERO;
    end else if (power_on && finish) begin
      // load at completion; the same SAR value in both modes
      result <= sar;
    end
  end

  // ******************************************************
  // control register
  // ******************************************************
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      adc_control <= `CTL_RESET;
    end else begin
      if (wr_control) begin
        adc_control[`CTL_POWER_ON]            <= SFR_WDATA[`CTL_POWER_ON];
        adc_control[`CTL_DIFF_MODE]           <= SFR_WDATA[`CTL_DIFF_MODE];
        adc_control[`CTL_AUTOZERO]            <= SFR_WDATA[`CTL_AUTOZERO];
        adc_control[`CTL_CHAN_HI:`CTL_CHAN_LO] <= SFR_WDATA[`CTL_CHAN_HI:`CTL_CHAN_LO];
        if (!SFR_WDATA[`CTL_DONE]) begin
          adc_control[`CTL_DONE] <= 1'b0;
        end
        if (SFR_WDATA[`CTL_GO]) begin
          adc_control[`CTL_GO] <= 1'b1;
        end
      end
      // completion clears go in soft trigger mode, sets flag; set wins
      if (power_on && finish) begin
        adc_control[`CTL_DONE] <= 1'b1;
        if (trigger_sel == `TRIG_SOFT) begin
          adc_control[`CTL_GO] <= 1'b0;
        end
      end
      // shutdown stops repeats
      if (!power_on && !(wr_control && SFR_WDATA[`CTL_POWER_ON])) begin
        adc_control[`CTL_GO] <= 1'b0;
      end
    end
  end

  // ******************************************************
  // config register
  // ******************************************************
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      adc_config <= `CFG_RESET;
    end else if (wr_config) begin
      adc_config <= SFR_WDATA & `CFG_WMASK;
    end
  end

  // ******************************************************
  // result justification and read mux
  // ******************************************************
  // justification, zero fill
  adc_result_pack u_pack (
    .right_justify (adc_config[`CFG_RJUST]),
    .value         (result),
    .high_byte     (result_high),
    .low_byte      (result_low)
  );

  // registered read data
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SFR_RDATA <= 8'h00;
    end else begin
      case (SFR_ADDR)
        `ADDR_CONFIG:      SFR_RDATA <= adc_config;
        `ADDR_CONTROL:     SFR_RDATA <= adc_control;
        `ADDR_RESULT_LOW:  SFR_RDATA <= result_low;
        `ADDR_RESULT_HIGH: SFR_RDATA <= result_high;
        default:           SFR_RDATA <= 8'h00;
      endcase
    end
  end

  // ******************************************************
  // analog side controls
  // ******************************************************
  // power output
  assign ADC_POWER_ON = power_on;
  assign DIFF_MODE    = adc_control[`CTL_DIFF_MODE];
  assign AUTOZERO_ON  = adc_control[`CTL_AUTOZERO];
  // single pin; even positive, odd negative
  assign PIN_SEL_POS  = !power_on ? 8'h00 :
                        DIFF_MODE ? (8'h01 << {chan_sel[2:1], 1'b0}) : (8'h01 << chan_sel);
  assign PIN_SEL_NEG  = (power_on && DIFF_MODE) ? (8'h02 << {chan_sel[2:1], 1'b0}) : 8'h00;

  assign ADC_IRQ = conv_done_flag && ADC_IRQ_EN;

endmodule // sar_adc_sequencer
`default_nettype wire
